// File: tpm_pads.sv
`include "tpm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tpm_pads #(
	parameter int RST_CYCLES = `TPM_RST_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       reset_in_n,
	input  wire logic [1:0] pin0_func_sel,
	input  wire logic [1:0] pin1_func_sel,
	input  wire logic [1:0] pin3_func_sel,
	input  wire logic [2:0] port_c_dir,
	input  wire logic [2:0] port_c_out,
	output logic      [2:0] port_c_in,
	input  wire logic       timer_c0_out,
	input  wire logic       timer_c0_oe,
	output logic            timer_c0_in,
	input  wire logic       timer_c1_out,
	input  wire logic       timer_c1_oe,
	output logic            timer_c1_in,
	input  wire logic       timer_c3_out,
	input  wire logic       timer_c3_oe,
	output logic            timer_c3_in,
	input  wire logic       serial_tx_out,
	output logic            serial_rx_in,
	input  wire logic       timer_c_chan_zero_pin_i,
	output logic            timer_c_chan_zero_pin_o,
	output logic            timer_c_chan_zero_pin_oe,
	input  wire logic       timer_c_chan_one_pin_i,
	output logic            timer_c_chan_one_pin_o,
	output logic            timer_c_chan_one_pin_oe,
	input  wire logic       timer_c_chan_three_pin_i,
	output logic            timer_c_chan_three_pin_o,
	output logic            timer_c_chan_three_pin_oe,
	input  wire logic       ext_irq_in_n,
	input  wire logic       low_power_mode,
	input  wire logic       irq_edge_mode,
	input  wire logic       irq_ack,
	output logic            irq_request,
	output logic            chip_rst_out
);
	localparam logic [7:0] RST_LAST = 8'(RST_CYCLES - 1);

	// on pins zero and one, alternate and gpio both take the pad away from the timer
	function automatic logic not_timer_fn(input logic [1:0] sel);
		return (sel == `TPM_FN_GPIO) || (sel == `TPM_FN_ALT);
	endfunction

	// reset: sys_rst or pad low asserts immediately; release is synced and counted
	logic       rst_async;
	logic       rst_s1_q;
	logic       rst_s2_q;
	logic [7:0] rst_cnt_q;
	tpm_pkg::tpm_rst_type rst_state_q;
	assign rst_async = sys_rst | ~reset_in_n;

	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			rst_state_q  <= tpm_pkg::TPM_RST_HOLD;
			rst_cnt_q    <= `TPM_RST_CNT_ZERO;
			chip_rst_out <= 1'b1;
		end else begin
			case (rst_state_q)
				tpm_pkg::TPM_RST_HOLD: begin
					if (rst_s2_q) begin
						rst_state_q <= tpm_pkg::TPM_RST_COUNT;
					end
				end
				tpm_pkg::TPM_RST_COUNT: begin
					rst_cnt_q <= 8'(rst_cnt_q + `TPM_RST_CNT_ONE);
					if (rst_cnt_q == RST_LAST) begin
						rst_state_q  <= tpm_pkg::TPM_RST_RUN;
						chip_rst_out <= 1'b0;
					end
				end
				tpm_pkg::TPM_RST_RUN: begin
					chip_rst_out <= 1'b0;
				end
				default: begin
					rst_state_q <= tpm_pkg::TPM_RST_HOLD;
				end
			endcase
		end
	end

	// pin muxing; test-port reset is the board's job, this block never touches it
	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			timer_c_chan_zero_pin_o   <= 1'b0;
			timer_c_chan_zero_pin_oe  <= 1'b0;
			timer_c_chan_one_pin_o    <= 1'b0;
			timer_c_chan_one_pin_oe   <= 1'b0;
			timer_c_chan_three_pin_o  <= 1'b0;
			timer_c_chan_three_pin_oe <= 1'b0;
		end else begin
			case (pin0_func_sel)
				`TPM_FN_ALT: begin
					timer_c_chan_zero_pin_o  <= serial_tx_out;
					timer_c_chan_zero_pin_oe <= 1'b1;
				end
				`TPM_FN_GPIO: begin
					timer_c_chan_zero_pin_o  <= port_c_out[2];
					timer_c_chan_zero_pin_oe <= port_c_dir[2];
				end
				default: begin
					timer_c_chan_zero_pin_o  <= timer_c0_out;
					timer_c_chan_zero_pin_oe <= timer_c0_oe;
				end
			endcase
			case (pin1_func_sel)
				`TPM_FN_ALT: begin
					timer_c_chan_one_pin_o  <= 1'b0;
					timer_c_chan_one_pin_oe <= 1'b0;
				end
				`TPM_FN_GPIO: begin
					timer_c_chan_one_pin_o  <= port_c_out[1];
					timer_c_chan_one_pin_oe <= port_c_dir[1];
				end
				default: begin
					timer_c_chan_one_pin_o  <= timer_c1_out;
					timer_c_chan_one_pin_oe <= timer_c1_oe;
				end
			endcase
			if (pin3_func_sel == `TPM_FN_GPIO) begin
				timer_c_chan_three_pin_o  <= port_c_out[0];
				timer_c_chan_three_pin_oe <= port_c_dir[0];
			end else begin
				timer_c_chan_three_pin_o  <= timer_c3_out;
				timer_c_chan_three_pin_oe <= timer_c3_oe;
			end
		end
	end

	// inputs toward the peripherals; timer and serial inputs are gated to idle high when unselected, port_c_in always sees the pads
	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			timer_c0_in  <= 1'b1;
			timer_c1_in  <= 1'b1;
			timer_c3_in  <= 1'b1;
			serial_rx_in <= 1'b1;
			port_c_in    <= 3'h7;
		end else begin
			timer_c0_in  <= not_timer_fn(pin0_func_sel) ? 1'b1 : timer_c_chan_zero_pin_i;
			timer_c1_in  <= not_timer_fn(pin1_func_sel) ? 1'b1 : timer_c_chan_one_pin_i;
			timer_c3_in  <= (pin3_func_sel == `TPM_FN_GPIO) ? 1'b1 : timer_c_chan_three_pin_i;
			serial_rx_in <= (pin1_func_sel == `TPM_FN_ALT) ? timer_c_chan_one_pin_i : 1'b1;
			port_c_in    <= {timer_c_chan_zero_pin_i, timer_c_chan_one_pin_i,
				timer_c_chan_three_pin_i};
		end
	end

	// irq: async latch catches a falling edge with no clock in low power
	logic irq_async_q;
	logic irq_async_clr;
	logic irq_lat_s1_q;
	logic irq_lat_s2_q;
	logic irq_lat_s3_q;
	logic irq_s1_q;
	logic irq_s2_q;
	logic irq_s3_q;
	logic irq_fall;
	assign irq_async_clr = rst_async | (irq_ack & irq_lat_s2_q);

	always_ff @(negedge ext_irq_in_n or posedge irq_async_clr) begin
		if (irq_async_clr) begin
			irq_async_q <= 1'b0;
		end else begin
			irq_async_q <= low_power_mode;
		end
	end

	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			irq_s1_q     <= 1'b1;
			irq_s2_q     <= 1'b1;
			irq_s3_q     <= 1'b1;
			irq_lat_s1_q <= 1'b0;
			irq_lat_s2_q <= 1'b0;
			irq_lat_s3_q <= 1'b0;
		end else begin
			irq_s1_q     <= ext_irq_in_n;
			irq_s2_q     <= irq_s1_q;
			irq_s3_q     <= irq_s2_q;
			irq_lat_s1_q <= irq_async_q;
			irq_lat_s2_q <= irq_lat_s1_q;
			irq_lat_s3_q <= irq_lat_s2_q;
		end
	end
	assign irq_fall = irq_s3_q & ~irq_s2_q;

	always_ff @(posedge clock or posedge rst_async) begin
		if (rst_async) begin
			irq_request <= 1'b0;
		end else if (!irq_edge_mode) begin
			irq_request <= ~irq_s2_q | irq_lat_s2_q;
		end else if (irq_fall || (irq_lat_s2_q && !irq_lat_s3_q)) begin
			// the synced fall or the latch's rise sets; the latch level lingers two clocks past irq_ack
			irq_request <= 1'b1;
		end else if (irq_ack) begin
			irq_request <= 1'b0;
		end
	end

	rst_count_a: assert property (@(posedge clock) disable iff (rst_async)
		$fell(chip_rst_out) |-> (rst_cnt_q == 8'(RST_CYCLES)))
		else $error("internal reset released too early");
	rst_hold_a: assert property (@(posedge clock) disable iff (rst_async)
		(rst_state_q != tpm_pkg::TPM_RST_RUN) |-> chip_rst_out)
		else $error("internal reset dropped before count end");
	rst_sync_a: assert property (@(posedge clock) disable iff (rst_async)
		!rst_s2_q |-> (rst_state_q == tpm_pkg::TPM_RST_HOLD))
		else $error("reset counter left hold before sync");
	rst_run_a: assert property (@(posedge clock) disable iff (rst_async)
		(rst_state_q == tpm_pkg::TPM_RST_RUN) |-> !chip_rst_out)
		else $error("internal reset stuck");
	pin0_timer_a: assert property (@(posedge clock) disable iff (rst_async)
		(pin0_func_sel == `TPM_FN_TIMER) |=> timer_c_chan_zero_pin_o == $past(timer_c0_out))
		else $error("pin zero not timer");
	pin1_timer_a: assert property (@(posedge clock) disable iff (rst_async)
		(pin1_func_sel == `TPM_FN_TIMER) |=> timer_c_chan_one_pin_oe == $past(timer_c1_oe))
		else $error("pin one not timer");
	pin3_gpio_a: assert property (@(posedge clock) disable iff (rst_async)
		(pin3_func_sel == `TPM_FN_GPIO) |=> timer_c_chan_three_pin_oe == $past(port_c_dir[0]))
		else $error("pin three gpio dir wrong");
	pin0_tx_a: assert property (@(posedge clock) disable iff (rst_async)
		(pin0_func_sel == `TPM_FN_ALT) |=> timer_c_chan_zero_pin_o == $past(serial_tx_out))
		else $error("serial tx not routed");
	pin1_rx_a: assert property (@(posedge clock) disable iff (rst_async)
		(pin1_func_sel == `TPM_FN_ALT) |=> serial_rx_in == $past(timer_c_chan_one_pin_i))
		else $error("serial rx not routed");
	sequence irq_low_held_s;
		(!irq_edge_mode && !ext_irq_in_n) [*3];
	endsequence
	sequence irq_fall_seen_s;
		(irq_edge_mode && ext_irq_in_n) ##1 (irq_edge_mode && !ext_irq_in_n) ##1 irq_edge_mode [*2];
	endsequence
	irq_level_a: assert property (@(posedge clock) disable iff (rst_async)
		irq_low_held_s |-> ##1 irq_request)
		else $error("level irq not requested");
	irq_edge_a: assert property (@(posedge clock) disable iff (rst_async)
		irq_fall_seen_s |=> irq_request)
		else $error("edge irq not requested");
endmodule
`default_nettype wire

// File: tpm_consts.svh
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH
`define TPM_FN_TIMER      2'h0
`define TPM_FN_ALT        2'h1
`define TPM_FN_GPIO       2'h2
`define TPM_RST_CYCLES    8'h20
`define TPM_RST_CNT_ZERO  8'h00
`define TPM_RST_CNT_ONE   8'h01
`endif

// File: tpm_pkg.sv
`default_nettype none
package tpm_pkg;
	typedef enum logic [1:0] {
		TPM_FN_TIMER_E = 2'h0,
		TPM_FN_ALT_E   = 2'h1,
		TPM_FN_GPIO_E  = 2'h2
	} tpm_func_type;
	typedef enum logic [2:0] {
		TPM_RST_HOLD  = 3'h1,
		TPM_RST_COUNT = 3'h2,
		TPM_RST_RUN   = 3'h4
	} tpm_rst_type;
endpackage
`default_nettype wire

// File: tpm_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_board_model (
	input  wire logic [2:0] pad_o,
	input  wire logic [2:0] pad_oe,
	input  wire logic [2:0] ext_en,
	input  wire logic [2:0] ext_val,
	output logic      [2:0] pad_i
);
	// pads carry pull-ups, so an undriven pin reads high
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			pad_i[k] = pad_oe[k] ? pad_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
		end
	end
endmodule
`default_nettype wire

// File: tpm_pads_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define TPM_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t: value mismatch", $time); end end
module tpm_pads_tb;
	logic       clock;
	logic       run = 1'b1;
	logic       sys_rst, reset_in_n, irq_n, lpm, edge_m, ack, tx, rx, irq, crst;
	logic [1:0] s0, s1, s3;
	logic [2:0] dir, pout, pin, tout, toe, tin, po, poe, pi, een, eval;
	int         mismatches, checks_done;

	tpm_pads #(.RST_CYCLES(4)) i_tpm_pads (
		.clock(clock), .sys_rst(sys_rst), .reset_in_n(reset_in_n),
		.pin0_func_sel(s0), .pin1_func_sel(s1), .pin3_func_sel(s3),
		.port_c_dir(dir), .port_c_out(pout), .port_c_in(pin),
		.timer_c0_out(tout[2]), .timer_c0_oe(toe[2]), .timer_c0_in(tin[2]),
		.timer_c1_out(tout[1]), .timer_c1_oe(toe[1]), .timer_c1_in(tin[1]),
		.timer_c3_out(tout[0]), .timer_c3_oe(toe[0]), .timer_c3_in(tin[0]),
		.serial_tx_out(tx), .serial_rx_in(rx),
		.timer_c_chan_zero_pin_i(pi[2]), .timer_c_chan_zero_pin_o(po[2]),
		.timer_c_chan_zero_pin_oe(poe[2]),
		.timer_c_chan_one_pin_i(pi[1]), .timer_c_chan_one_pin_o(po[1]),
		.timer_c_chan_one_pin_oe(poe[1]),
		.timer_c_chan_three_pin_i(pi[0]), .timer_c_chan_three_pin_o(po[0]),
		.timer_c_chan_three_pin_oe(poe[0]),
		.ext_irq_in_n(irq_n), .low_power_mode(lpm), .irq_edge_mode(edge_m),
		.irq_ack(ack), .irq_request(irq), .chip_rst_out(crst)
	);
	tpm_board_model i_tpm_board_model (
		.pad_o(po), .pad_oe(poe), .ext_en(een), .ext_val(eval), .pad_i(pi)
	);

	initial begin
		clock = 1'b0;
		forever #12.5 if (run) clock = ~clock;
	end

	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task t_reset;
		tick(12);
		sys_rst = 1'b0;
		tick(3);
		`TPM_CHECK(crst, 1'b1)
		reset_in_n = 1'b1;
		tick(5);
		`TPM_CHECK(crst, 1'b1)
		tick(4);
		`TPM_CHECK(crst, 1'b0)
	endtask

	task t_timer;
		s3 = 2'h1; // alternate on pin three falls back to the timer
		tout = 3'b101;
		toe = 3'b110;
		tick(2);
		`TPM_CHECK(po[2:1], tout[2:1])
		`TPM_CHECK(poe, toe)
		`TPM_CHECK(po, 3'b101)
		`TPM_CHECK(tin, 3'b101)
	endtask

	task t_alt;
		s0 = 2'h1;
		s1 = 2'h1;
		tx = 1'b1;
		een = 3'b010;
		tick(2);
		`TPM_CHECK({po[2], poe[2]}, 2'h3)
		`TPM_CHECK({poe[1], rx}, 2'h0)
		tx = 1'b0;
		eval = 3'b010;
		tick(2);
		`TPM_CHECK({po[2], rx}, 2'h1)
		`TPM_CHECK(tin[2:1], 2'h3)
	endtask

	task t_gpio;
		{s0, s1, s3} = 6'h2A;
		dir = 3'b101;
		pout = 3'b001;
		eval = 3'b000;
		tick(2);
		`TPM_CHECK(poe, 3'h5)
		`TPM_CHECK(pin, 3'h1)
		`TPM_CHECK(tin, 3'h7)
		`TPM_CHECK(rx, 1'b1)
	endtask

	task t_irq;
		irq_n = 1'b0;
		tick(1);
		`TPM_CHECK(irq, 1'b0)
		tick(3);
		`TPM_CHECK(irq, 1'b1)
		irq_n = 1'b1;
		edge_m = 1'b1;
		tick(1);
		`TPM_CHECK(irq, 1'b1)
		ack = 1'b1; // request from level mode stands until acknowledged
		tick(1);
		ack = 1'b0;
		tick(2);
		`TPM_CHECK(irq, 1'b0)
		irq_n = 1'b0;
		tick(1);
		irq_n = 1'b1;
		tick(4);
		`TPM_CHECK(irq, 1'b1)
		ack = 1'b1;
		tick(1);
		ack = 1'b0;
		lpm = 1'b1;
		tick(2);
		`TPM_CHECK(irq, 1'b0)
		// the clock halts as in stop mode; the edge must still be caught
		run = 1'b0;
		#100 irq_n = 1'b0;
		#100 irq_n = 1'b1;
		#110 run = 1'b1; // off the half-period grid, no race with the clock loop
		tick(5);
		`TPM_CHECK(irq, 1'b1)
	endtask

	initial begin
		{sys_rst, reset_in_n, irq_n, lpm, edge_m, ack, tx} = 7'b1010000;
		{s0, s1, s3} = 6'h00;
		{dir, pout, tout, toe, een, eval} = 18'h00000;
		mismatches = 0;
		checks_done = 0;
		t_reset();
		t_timer();
		t_alt();
		t_gpio();
		t_irq();
		print_verdict();
	end

	initial begin
		#20000;
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
